// ### shh_pkg.sv
`default_nettype none
package shh_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACQ_TIME_NS = 16000;
    localparam int CAL_TIME_NS = 45000;
    // acquisition length rounds up so the core always gets its full time
    localparam logic [15:0] ACQ_CYCLES =
        16'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] CAL_CYCLES =
        16'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // serial word layout and lengths
    // ****************************************
    localparam logic [4:0] CMD_LAST = 5'h09;
    localparam logic [4:0] RB_LAST = 5'h0D;
    localparam logic [4:0] TEST_LAST = 5'h17;
    localparam int CMD_MODE_HI = 9;
    localparam int CMD_MODE_LO = 8;
    localparam int CMD_CAL = 7;
    localparam int CMD_OFFS = 6;
    localparam int CMD_TEST = 5;
    localparam int CODE_W = 14;
    localparam int NUM_CH = 33;
    localparam logic [5:0] OFFSET_CH = 6'h20;

    typedef enum logic [1:0] {
        MODE_HOLD = 2'h0,
        MODE_TEST = 2'h1,
        MODE_ACQ_RB = 2'h2,
        MODE_RB = 2'h3
    } shh_mode_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'h0,
        SER_RX = 2'h1,
        SER_TX = 2'h3
    } shh_ser_t;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] REG_ACQ_TIME = 8'h00;
    localparam logic [7:0] REG_CAL_TIME = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LAST_CMD = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### shh_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module shh_sync2 #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // two stages; only the second is visible outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### shh_host_if.sv
// Functional notes
// - readback-only mode addresses a channel and starts no acquisition
// - after a readback-mode command, next frame shifts out 14-bit code
// - strap high: serial port used, parallel inputs ignored
// - strap low: parallel port used, serial port ignored
// - one active-low pin is frame select and chip select
// - readback bit launched on rising clock, host samples on falling
// - calibrate-all makes all 32 channels acquire, longer time
// - offset select targets offset channel, address bits ignored
// - five-bit address picks one of 32 channels, MSB first
// - frame fall clears counter; further frame edges ignored until done
// - after full count, clock edges ignored until next frame fall
// - output driven from first rise, released on 14th falling edge
// - input bits taken on falling clock edges, MSB first
// - nothing shifts before a frame-select falling edge
// - works with continuous or gated shift clock
// - parallel: address pins latched on write strobe rising edge
// - parallel: offset pin high targets offset channel
// - parallel: calibrate pin high makes all 32 channels acquire
// - mode bits: hold, acquire+readback, readback; 01 test until 24 clocks
// - hold-acquire mode: addressed channel acquires and updates its code
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module shh_host_if
    import shh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic interface_select,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic sdin,
    output logic sdout,
    output logic sdout_oe,
    input wire logic wr_n,
    input wire logic [4:0] channel_addr,
    input wire logic offset_sel,
    input wire logic cal_all,
    input wire logic [13:0] conv_code,
    output logic acq_start,
    output logic [5:0] acq_channel,
    output logic acq_all,
    output logic acq_busy
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        shh_ser_t st;
        logic [4:0] cnt;
        logic [9:0] sh;
        logic [13:0] rd;
        logic oe;
        logic dout;
        logic rb_pend;
        logic [5:0] rb_ch;
        logic test;
        logic busy;
        logic [15:0] tmr;
        logic [5:0] tgt;
        logic all;
        logic acq_pulse;
        logic [NUM_CH-1:0][CODE_W-1:0] mem;
        logic sclk_p;
        logic sync_p;
        logic wr_p;
        logic [15:0] acq_time;
        logic [15:0] cal_time;
        logic [9:0] last_cmd;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } shh_state_t;

    shh_state_t q;
    shh_state_t n;

    // ****************************************
    // pin synchronisers and edges
    // ****************************************
    logic [11:0] pins_s;
    logic s_sclk, s_sync, s_sync_n, s_din, s_wr, s_wr_n, s_sel, s_offs, s_cal;
    logic [4:0] s_addr;

    shh_sync2 #(.W(12)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({sclk, ~frame_sel_n, sdin, ~wr_n, interface_select,
                   channel_addr, offset_sel, cal_all}),
        .sync_out(pins_s)
    );

    // active-low pins travel inverted so a cleared synchroniser reads as idle, not an edge
    assign {s_sclk, s_sync, s_din, s_wr, s_sel, s_addr, s_offs, s_cal} = pins_s;
    assign s_sync_n = !s_sync;
    assign s_wr_n = !s_wr;

    logic sclk_rise, sclk_fall, sync_fall, wr_rise, sel_ser;
    // the clock is only watched for edges, so a free-running one is harmless
    assign sclk_rise = !q.sclk_p && s_sclk;
    assign sclk_fall = q.sclk_p && !s_sclk;
    assign sync_fall = q.sync_p && !s_sync_n;
    assign wr_rise = !q.wr_p && s_wr_n;
    assign sel_ser = s_sel;

    // ****************************************
    // command decode
    // ****************************************
    logic [9:0] cmd_w;
    logic cmd_done, test_exit, par_wr, ser_acq, acq_go, acq_allv;
    shh_mode_t cmd_mode;
    logic [5:0] cmd_tgt, par_tgt, acq_ch;
    logic [4:0] rx_last;

    assign rx_last = q.test ? TEST_LAST : CMD_LAST;
    assign cmd_w = {q.sh[8:0], s_din};
    assign cmd_done = (q.st == SER_RX) && sclk_fall && (q.cnt == CMD_LAST) && !q.test;
    assign test_exit = (q.st == SER_RX) && sclk_fall && (q.cnt == TEST_LAST) && q.test;
    // field order: mode, cal, offset, test, address (test bit unused)
    assign cmd_mode = shh_mode_t'(cmd_w[CMD_MODE_HI:CMD_MODE_LO]);
    assign cmd_tgt = cmd_w[CMD_OFFS] ? OFFSET_CH : {1'b0, cmd_w[4:0]};
    assign par_tgt = s_offs ? OFFSET_CH : {1'b0, s_addr};
    assign par_wr = !sel_ser && wr_rise && !s_sync_n;
    // readback-only mode never reaches the acquisition path
    assign ser_acq = cmd_done && (cmd_mode == MODE_HOLD || cmd_mode == MODE_ACQ_RB);
    assign acq_go = ser_acq || par_wr;
    assign acq_ch = par_wr ? par_tgt : cmd_tgt;
    assign acq_allv = par_wr ? s_cal : cmd_w[CMD_CAL];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = q;
        n.acq_pulse = 1'b0;
        n.sclk_p = s_sclk;
        n.sync_p = s_sync_n;
        n.wr_p = s_wr_n;
        // serial engine; frame edges only matter while idle
        unique case (q.st)
            SER_IDLE: begin
                if (sel_ser && sync_fall) begin
                    n.cnt = 5'h00;
                    if (q.rb_pend) begin
                        n.st = SER_TX;
                        n.rd = q.mem[q.rb_ch];
                        n.rb_pend = 1'b0;
                    end else begin
                        n.st = SER_RX;
                    end
                end
            end
            SER_RX: begin
                if (sclk_fall) begin
                    n.sh = cmd_w;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == rx_last) begin
                        n.st = SER_IDLE;
                    end
                end
            end
            SER_TX: begin
                // input line not sampled here
                if (sclk_rise) begin
                    n.oe = 1'b1;
                    n.dout = q.rd[CODE_W-1];
                    n.rd = {q.rd[CODE_W-2:0], 1'b0};
                end
                if (sclk_fall) begin
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == RB_LAST) begin
                        n.oe = 1'b0;
                        n.st = SER_IDLE;
                    end
                end
            end
            default: begin
                n.st = SER_IDLE;
            end
        endcase
        // strap moving mid-frame aborts; the port is simply not selected
        if (!sel_ser) begin
            n.st = SER_IDLE;
            n.oe = 1'b0;
        end
        if (cmd_done) begin
            n.last_cmd = cmd_w;
            unique case (cmd_mode)
                MODE_TEST: n.test = 1'b1;
                MODE_ACQ_RB, MODE_RB: begin
                    n.rb_pend = 1'b1;
                    n.rb_ch = cmd_tgt;
                end
                MODE_HOLD: n.rb_pend = 1'b0;
            endcase
        end
        if (test_exit) begin
            n.test = 1'b0;
        end
        // acquisition timer; a new command restarts it
        if (acq_go) begin
            n.busy = 1'b1;
            n.tgt = acq_ch;
            n.all = acq_allv;
            n.tmr = acq_allv ? q.cal_time : q.acq_time;
            n.acq_pulse = 1'b1;
        end else if (q.busy) begin
            if (q.tmr <= 16'h0001) begin
                n.busy = 1'b0;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (q.all ? (i < NUM_CH - 1) : (i == int'(q.tgt))) begin
                        n.mem[i] = conv_code;
                    end
                end
            end else begin
                n.tmr = q.tmr - 16'h0001;
            end
        end
        // axi write: address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awaddr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            unique case (q.awaddr)
                REG_ACQ_TIME: begin
                    if (q.wstrb[0]) n.acq_time[7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) n.acq_time[15:8] = q.wdata[15:8];
                end
                REG_CAL_TIME: begin
                    if (q.wstrb[0]) n.cal_time[7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) n.cal_time[15:8] = q.wdata[15:8];
                end
                REG_STATUS, REG_LAST_CMD: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
        end
        // axi read: one cycle to answer
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                REG_ACQ_TIME: n.rdata = {16'h0000, q.acq_time};
                REG_CAL_TIME: n.rdata = {16'h0000, q.cal_time};
                REG_STATUS: n.rdata = {26'h0000000, q.test, q.busy, q.rb_pend,
                                       sel_ser, q.st};
                REG_LAST_CMD: n.rdata = {22'h000000, q.last_cmd};
                default: begin
                    n.rdata = 32'h00000000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    // ****************************************
    // register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{st: SER_IDLE, acq_time: ACQ_CYCLES, cal_time: CAL_CYCLES,
                   sync_p: 1'b1, wr_p: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign sdout = q.dout;
    assign sdout_oe = q.oe;
    assign acq_start = q.acq_pulse;
    assign acq_channel = q.tgt;
    assign acq_all = q.all;
    assign acq_busy = q.busy;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rb_no_acq_a: assert property (cmd_done && cmd_mode == MODE_RB |=> !acq_start)
        else $error("readback-only command started acquisition");
    rb_arm_a: assert property (cmd_done && cmd_mode[1] |=> q.rb_pend && q.rb_ch == $past(cmd_tgt))
        else $error("readback not armed after command");
    par_ignored_a: assert property (sel_ser && wr_rise && !cmd_done |=> !acq_start)
        else $error("parallel strobe acted in serial operation");
    par_latch_a: assert property (par_wr |=> acq_start && acq_channel == $past(par_tgt))
        else $error("parallel write not latched");
    offs_tgt_a: assert property (ser_acq && cmd_w[CMD_OFFS] |=> acq_channel == OFFSET_CH)
        else $error("offset select ignored");
    cal_time_a: assert property (acq_start && acq_all |-> q.tmr == q.cal_time)
        else $error("calibrate-all used wrong time");
    rx_hold_a: assert property (q.st == SER_RX && !sclk_fall |=> $stable(q.cnt))
        else $error("counter moved without clock in frame");
    idle_stay_a: assert property (q.st == SER_IDLE && !sync_fall |=> q.st == SER_IDLE)
        else $error("frame started without frame edge");
    idle_noshift_a: assert property (q.st == SER_IDLE |=> $stable(q.sh))
        else $error("shifted while idle");
    oe_frame_a: assert property (sdout_oe |-> q.st == SER_TX)
        else $error("output driven outside readback");
    oe_release_a: assert property (q.st == SER_TX && sclk_fall && q.cnt == RB_LAST |=> !sdout_oe)
        else $error("output not released at 14th fall");
    launch_a: assert property ($changed(sdout) |-> $past(sclk_rise))
        else $error("data launched off rising edge");
    tx_nodin_a: assert property (q.st == SER_TX |=> $stable(q.sh))
        else $error("input sampled during readback");
    test_mode_a: assert property (cmd_done && cmd_mode == MODE_TEST |=> q.test ##1 q.test)
        else $error("test mode not entered");

    ser_acq_c: cover property (ser_acq ##[1:500] !acq_busy);
    rb_done_c: cover property (q.st == SER_TX ##[1:500] q.st == SER_IDLE);
    par_wr_c: cover property (par_wr);
    test_exit_c: cover property (test_exit);
endmodule
`default_nettype wire

// ### shh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// host end of the serial and parallel ports
// ****
module shh_host_model (
    output logic frame_sel_n,
    output logic sclk,
    output logic sdin,
    input wire logic sdout,
    input wire logic sdout_oe,
    output logic wr_n,
    output logic [4:0] channel_addr,
    output logic offset_sel,
    output logic cal_all
);
    localparam int HALF_NS = 160;
    // idle levels; the gated clock rests low between frames
    initial begin
        frame_sel_n = 1'b1;
        sclk = 1'b0;
        sdin = 1'b0;
        wr_n = 1'b1;
        channel_addr = 5'h00;
        offset_sel = 1'b0;
        cal_all = 1'b0;
    end
    // one frame of n clocks, msb first both ways; in a 14-clock frame ok drops on a bad output enable
    task automatic frame(input int n, input logic [23:0] word, output logic [13:0] rd,
                         output logic ok);
        rd = 14'h0000;
        ok = 1'b1;
        #7;
        frame_sel_n = 1'b0;
        #200;
        if (n == 14 && sdout_oe !== 1'b0) ok = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            sdin = word[i];
            #HALF_NS;
            sclk = 1'b0;
            rd = {rd[12:0], sdout_oe ? sdout : ~sdout};
            if (n == 14 && sdout_oe !== 1'b1) ok = 1'b0;
            #HALF_NS;
        end
        sdin = ~sdin;  // a released line must not look stable
        if (n == 14 && sdout_oe !== 1'b0) ok = 1'b0;
        frame_sel_n = 1'b1;
        #400;  // gap before any next frame
    endtask
    // strobe the address pins with chip select low
    task automatic par_write(input logic [4:0] a, input logic offs, input logic cal);
        #7;
        frame_sel_n = 1'b0;
        channel_addr = a;
        offset_sel = offs;
        cal_all = cal;
        wr_n = 1'b0;
        #200;
        wr_n = 1'b1;
        #200;
        channel_addr = ~a;  // pins move after the strobe and must not count
        frame_sel_n = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ### test_sample_hold_host_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_sample_hold_host_interface
    import shh_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic interface_select = 1'b1;
    logic [13:0] conv_code = 14'h0000;
    logic awready, wready, bvalid, arready, rvalid, sdout, sdout_oe;
    logic acq_start, acq_all, acq_busy, frame_sel_n, sclk, sdin, wr_n, offset_sel, cal_all;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] acq_channel;
    logic [4:0] channel_addr;
    logic [13:0] exp_code [0:32] = '{default: 14'h0000};
    int errors = 0;
    int compares = 0;
    int starts = 0;
    int busy_len = 0;
    int last_busy = 0;
    int seed = 32'hb2e8000c;

    always #20 aclk = ~aclk;

    shh_host_if shh_host_if_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .interface_select(interface_select), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe), .wr_n(wr_n),
        .channel_addr(channel_addr), .offset_sel(offset_sel), .cal_all(cal_all),
        .conv_code(conv_code), .acq_start(acq_start), .acq_channel(acq_channel),
        .acq_all(acq_all), .acq_busy(acq_busy)
    );

    shh_host_model host_i (
        .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .sdout(sdout),
        .sdout_oe(sdout_oe), .wr_n(wr_n), .channel_addr(channel_addr),
        .offset_sel(offset_sel), .cal_all(cal_all)
    );

    // ****
    // monitor: counts acquisition starts and busy length
    // ****
    always @(posedge aclk) begin
        if (acq_start === 1'b1) starts <= starts + 1;
        if (acq_busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            last_busy <= busy_len;
            busy_len <= 0;
        end
    end

    // ****
    // checking helpers
    // ****
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one write or read; ready is looked at mid-cycle, where it has settled
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        logic [2:0] hs;
        logic done;
        int n;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        while (!done && n < 100) begin
            @(negedge aclk);
            hs = {awready & awvalid, wready & wvalid | arready & arvalid, w ? bvalid : rvalid};
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge aclk);
            if (hs[2]) awvalid <= 1'b0;
            if (hs[1]) wvalid <= 1'b0;
            if (hs[1]) arvalid <= 1'b0;
            if (hs[0]) bready <= 1'b0;
            if (hs[0]) rready <= 1'b0;
            done = hs[0];
            n++;
        end
        chk("bus answer", 1, done);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        axi(1'b0, a, 32'h00000000, q, r);
        chk("rdata", e, q);
        chk("rresp", er, r);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        axi(1'b1, a, d, q, r);
        chk("bresp", er, r);
    endtask

    // waits out any acquisition under a bound, ends mid-cycle
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (8) @(negedge aclk);
        while (acq_busy !== 1'b0 && n < 2000) begin
            @(negedge aclk);
            n++;
        end
        @(negedge aclk);
        chk("busy ends", 1, n < 2000);
    endtask

    // command, check its acquisition, and read the code back in readback modes
    task automatic run(input logic [1:0] m, input logic c, input logic o, input logic [4:0] a,
                       input logic par, input logic ext);
        int s0;
        logic [5:0] ch;
        logic [9:0] cmd;
        logic [13:0] rd;
        logic ok;
        s0 = starts;
        ch = o ? OFFSET_CH : {1'b0, a};
        cmd = {m, c, o, 1'b0, a};  // test bit kept zero
        @(posedge aclk);
        conv_code <= 14'($random(seed));
        if (par) begin
            host_i.par_write(a, o, c);
        end else begin
            host_i.frame(ext ? 12 : 10, ext ? {12'h000, cmd, 2'b11} : {14'h0000, cmd}, rd, ok);
        end
        wait_idle;
        if (!m[0]) begin
            chk("acq starts", 1, starts - s0);
            if (!c) chk("acq channel", ch, acq_channel);
            chk("acq all", c, acq_all);
            chk("busy cycles", c ? 6 : 4, last_busy);
            for (int i = 0; i < 33; i++) begin
                if (c ? i < 32 : i == ch) exp_code[i] = conv_code;
            end
        end else begin
            chk("acq starts", 0, starts - s0);
        end
        if (m[1]) begin
            host_i.frame(14, 24'($random(seed)), rd, ok);
            chk("readback code", exp_code[ch], rd);
            chk("readback oe", 1, ok);
        end
        $display("test mode %b chan %h done", m, ch);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        logic [4:0] a;
        logic [13:0] rd;
        logic ok;
        int s0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        reg_rd(REG_ACQ_TIME, 32'h00000190, RESP_OKAY);
        reg_rd(REG_CAL_TIME, 32'h00000465, RESP_OKAY);
        reg_rd(REG_STATUS, 32'h00000004, RESP_OKAY);
        reg_rd(8'h10, 32'h00000000, RESP_SLVERR);
        reg_wr(REG_ACQ_TIME, 32'hFFFF0004, RESP_OKAY);
        reg_wr(REG_CAL_TIME, 32'h00000006, RESP_OKAY);
        reg_wr(8'h24, 32'h00000001, RESP_SLVERR);
        reg_rd(REG_ACQ_TIME, 32'h00000004, RESP_OKAY);
        $display("test registers done");
        // boundary addresses, offset channel, trailing extra clocks
        run(2'b00, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        run(2'b11, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
        run(2'b00, 1'b0, 1'b0, 5'h1F, 1'b0, 1'b1);
        run(2'b11, 1'b0, 1'b0, 5'h1F, 1'b0, 1'b1);
        run(2'b10, 1'b0, 1'b1, 5'h0A, 1'b0, 1'b0);
        run(2'b11, 1'b0, 1'b1, 5'h13, 1'b0, 1'b0);
        reg_rd(REG_LAST_CMD, 32'h00000353, RESP_OKAY);
        // random commands, each read back afterwards
        for (int k = 0; k < 6; k++) begin
            a = 5'($random(seed));
            ok = 1'($random(seed) % 4 == 0);
            run({1'($random(seed)), 1'b0}, 1'b0, ok, a, 1'b0, 1'($random(seed)));
            run(2'b11, 1'b0, ok, a, 1'b0, 1'b0);
        end
        run(2'b00, 1'b1, 1'b0, a, 1'b0, 1'b0);
        run(2'b11, 1'b0, 1'b0, ~a, 1'b0, 1'b0);
        // test mode and its long clearing write
        run(2'b01, 1'b0, 1'b0, 5'h03, 1'b0, 1'b0);
        reg_rd(REG_STATUS, 32'h00000024, RESP_OKAY);
        @(posedge aclk);
        host_i.frame(24, 24'h000000, rd, ok);
        reg_rd(REG_STATUS, 32'h00000004, RESP_OKAY);
        $display("test test mode done");
        // parallel port, then each port ignored under the other strap
        @(posedge aclk);
        interface_select <= 1'b0;
        repeat (4) @(posedge aclk);
        run(2'b00, 1'b0, 1'b0, 5'h09, 1'b1, 1'b0);
        run(2'b00, 1'b0, 1'b1, 5'h09, 1'b1, 1'b0);
        run(2'b00, 1'b1, 1'b0, 5'h02, 1'b1, 1'b0);
        s0 = starts;
        host_i.frame(10, 24'h000005, rd, ok);
        @(posedge aclk);
        interface_select <= 1'b1;
        repeat (4) @(posedge aclk);
        host_i.par_write(5'h06, 1'b0, 1'b0);
        wait_idle;
        chk("ignored port", s0, starts);
        $display("test ignored port done");
        run(2'b11, 1'b0, 1'b0, 5'h09, 1'b0, 1'b0);
        run(2'b11, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0);
        results;
    end

    // watchdog sized well past the whole sequence
    initial begin
        #3000000;
        errors++;
        $display("BAD watchdog expected finish seen hang");
        results;
    end
endmodule
`default_nettype wire
